// ==== core/ata_rd_pkg.sv ====
package ata_rd_pkg;
  // task-file register indices
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_ERROR = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_SECT = 3'h3;
  localparam logic [2:0] TF_CYL_LO = 3'h4;
  localparam logic [2:0] TF_CYL_HI = 3'h5;
  localparam logic [2:0] TF_DEV_HEAD = 3'h6;
  localparam logic [2:0] TF_STATUS = 3'h7;
  // command codes
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_READ_NR = 8'h21;
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR = 8'h41;
  localparam logic [7:0] CMD_READ_MULT = 8'hC4;
  localparam logic [7:0] CMD_NATIVE_MAX = 8'hF8;
  // status and error bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABT = 2;
  // device/head field layout
  localparam int DH_LBA = 6;
  localparam int DH_DEV = 4;
  localparam logic [7:0] DH_FIXED = 8'hA0;
  // sector sizing
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [8:0] ZERO_COUNT_SECTORS = 9'h100;
  localparam logic [8:0] ONE_SECTOR = 9'h001;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 16;

  typedef struct packed {
    logic [3:0] head;
    logic [15:0] cyl;
    logic [7:0] sect;
  } tf_addr_s;

  typedef struct packed {
    tf_addr_s addr;
    logic lba;
    logic retry_off;
    logic stream;
  } media_req_s;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_DRQ} exec_state_e;
endpackage : ata_rd_pkg

// ==== core/word_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // async reset, low
  input wire logic flush, // drop all contents
  input wire logic in_valid, // write offered
  output logic in_ready, // room available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;
  logic [AW:0] next_fill;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_fill = fill;
    if (push && !pop) next_fill = fill + 1'b1;
    else if (pop && !push) next_fill = fill - 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  // flags registered so full and empty never glitch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      fill <= next_fill;
      in_ready <= (next_fill != (AW+1)'(DEPTH));
      out_valid <= (next_fill != '0);
    end
  end
endmodule : word_fifo
`default_nettype wire

// ==== core/addr_stepper.sv ====
`timescale 1ns/1ns
`default_nettype none
module addr_stepper #(
  parameter logic [7:0] MAX_SECT = 8'h3F,
  parameter logic [3:0] MAX_HEAD = 4'hF
) (
  input wire ata_rd_pkg::tf_addr_s cur, // current sector address
  input wire logic lba, // logical-block mode
  output ata_rd_pkg::tf_addr_s nxt // following sector address
);
  logic [27:0] lin;

  assign lin = {cur.head, cur.cyl, cur.sect} + 28'h0000001;

  always_comb begin
    nxt = cur;
    if (lba) begin
      nxt = lin;
    end else if (cur.sect < MAX_SECT) begin
      nxt.sect = cur.sect + 8'h01;
    end else begin
      // sectors count from one in this mode
      nxt.sect = 8'h01;
      if (cur.head < MAX_HEAD) begin
        nxt.head = cur.head + 4'h1;
      end else begin
        nxt.head = 4'h0;
        nxt.cyl = cur.cyl + 16'h0001;
      end
    end
  end
endmodule : addr_stepper
`default_nettype wire

// ==== core/ata_read_command_executor.sv ====
`timescale 1ns/1ns
`default_nettype none
module ata_read_command_executor #(
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h0FFFFFF,
  parameter logic [15:0] NATIVE_MAX_CYL = 16'h3FFF,
  parameter logic [3:0] NATIVE_MAX_HEAD = 4'hF,
  parameter logic [7:0] NATIVE_MAX_SECT = 8'h3F
) (
  input wire logic mclk, // 10 MHz clock
  input wire logic rst_b, // async reset, low
  input wire logic [2:0] tf_addr, // task-file register index
  input wire logic tf_wr, // register write strobe
  input wire logic tf_rd, // register read strobe
  input wire logic [7:0] tf_wdata, // write byte
  output logic [15:0] tf_rdata, // read data, one cycle after strobe
  output logic intrq, // host interrupt level
  input wire logic [7:0] multiple_count, // sectors per block for multi read
  output logic med_req, // media sector request pulse
  output ata_rd_pkg::media_req_s med_cmd, // request details
  input wire logic med_ack, // media answer pulse
  input wire logic med_unc, // sector uncorrectable, with ack
  input wire logic med_word_valid, // media data word offered
  output logic med_word_ready, // buffer can take a word
  input wire logic [15:0] med_word // media data word
);
  ata_rd_pkg::exec_state_e state;
  ata_rd_pkg::tf_addr_s addr;
  ata_rd_pkg::tf_addr_s step_addr;
  logic [8:0] tf_count;
  logic [7:0] err_reg;
  logic err;
  logic lba;
  logic dev;
  logic [7:0] cur_cmd;
  logic is_verify;
  logic is_mult;
  logic [7:0] word_cnt;
  logic [7:0] blk_cnt;
  logic [7:0] status;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic cmd_wr;
  logic pop;
  logic sector_done;
  logic ack_ok;
  logic irq_set;
  logic irq_clr;

  // ---------------------------------------------------------------
  // decode and helpers
  // ---------------------------------------------------------------
  assign cmd_wr = tf_wr && (tf_addr == ata_rd_pkg::TF_STATUS) && (state == ata_rd_pkg::S_IDLE);
  assign pop = tf_rd && (tf_addr == ata_rd_pkg::TF_DATA) && (state == ata_rd_pkg::S_DRQ)
               && fifo_valid;
  assign sector_done = pop && (word_cnt == ata_rd_pkg::LAST_WORD);
  assign ack_ok = (state == ata_rd_pkg::S_WAIT) && med_ack && !med_unc;

  always_comb begin
    status = 8'h00;
    status[ata_rd_pkg::ST_BSY] = (state == ata_rd_pkg::S_ISSUE)
                                 || (state == ata_rd_pkg::S_WAIT);
    status[ata_rd_pkg::ST_RDY] = 1'b1;
    status[ata_rd_pkg::ST_DSC] = 1'b1;
    status[ata_rd_pkg::ST_DRQ] = (state == ata_rd_pkg::S_DRQ) && fifo_valid;
    status[ata_rd_pkg::ST_ERR] = err;
  end

  addr_stepper #(
    .MAX_SECT(NATIVE_MAX_SECT),
    .MAX_HEAD(NATIVE_MAX_HEAD)
  ) u_step (
    .cur(addr),
    .lba(lba),
    .nxt(step_addr)
  );

  // verify never streams, so the buffer only ever holds read data
  word_fifo #(
    .WIDTH(ata_rd_pkg::WORD_W),
    .DEPTH(ata_rd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(cmd_wr),
    .in_valid(med_word_valid),
    .in_ready(med_word_ready),
    .in_data(med_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ---------------------------------------------------------------
  // command sequencing and task file
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ata_rd_pkg::S_IDLE;
      addr <= '0;
      tf_count <= '0;
      err_reg <= 8'h00;
      err <= 1'b0;
      lba <= 1'b0;
      dev <= 1'b0;
      cur_cmd <= 8'h00;
      is_verify <= 1'b0;
      is_mult <= 1'b0;
    end else begin
      unique case (state)
        ata_rd_pkg::S_IDLE: begin
          // host may only rewrite the task file while no command is running
          if (tf_wr) begin
            unique case (tf_addr)
              ata_rd_pkg::TF_COUNT: tf_count <= {1'b0, tf_wdata};
              ata_rd_pkg::TF_SECT: addr.sect <= tf_wdata;
              ata_rd_pkg::TF_CYL_LO: addr.cyl[7:0] <= tf_wdata;
              ata_rd_pkg::TF_CYL_HI: addr.cyl[15:8] <= tf_wdata;
              ata_rd_pkg::TF_DEV_HEAD: begin
                addr.head <= tf_wdata[3:0];
                lba <= tf_wdata[ata_rd_pkg::DH_LBA];
                dev <= tf_wdata[ata_rd_pkg::DH_DEV];
              end
              default: ;
            endcase
          end
          if (cmd_wr) begin
            cur_cmd <= tf_wdata;
            err <= 1'b0;
            err_reg <= 8'h00;
            is_verify <= (tf_wdata == ata_rd_pkg::CMD_VERIFY)
                         || (tf_wdata == ata_rd_pkg::CMD_VERIFY_NR);
            is_mult <= (tf_wdata == ata_rd_pkg::CMD_READ_MULT);
            unique case (tf_wdata)
              ata_rd_pkg::CMD_READ, ata_rd_pkg::CMD_READ_NR, ata_rd_pkg::CMD_READ_MULT,
              ata_rd_pkg::CMD_VERIFY, ata_rd_pkg::CMD_VERIFY_NR: begin
                if (tf_count == '0) tf_count <= ata_rd_pkg::ZERO_COUNT_SECTORS;
                state <= ata_rd_pkg::S_ISSUE;
              end
              ata_rd_pkg::CMD_NATIVE_MAX: begin
                // fixed geometry; a host-set limit never reaches here
                if (lba) addr <= NATIVE_MAX_LBA;
                else addr <= {NATIVE_MAX_HEAD, NATIVE_MAX_CYL, NATIVE_MAX_SECT};
              end
              default: begin
                err <= 1'b1;
                err_reg[ata_rd_pkg::ER_ABT] <= 1'b1;
              end
            endcase
          end
        end
        ata_rd_pkg::S_ISSUE: state <= ata_rd_pkg::S_WAIT;
        ata_rd_pkg::S_WAIT: begin
          if (med_ack && med_unc) begin
            // failing sector stays in the address registers
            err <= 1'b1;
            err_reg[ata_rd_pkg::ER_UNC] <= 1'b1;
            state <= ata_rd_pkg::S_IDLE;
          end else if (ack_ok && is_verify) begin
            tf_count <= tf_count - ata_rd_pkg::ONE_SECTOR;
            if (tf_count == ata_rd_pkg::ONE_SECTOR) begin
              state <= ata_rd_pkg::S_IDLE;
            end else begin
              addr <= step_addr;
              state <= ata_rd_pkg::S_ISSUE;
            end
          end else if (ack_ok) begin
            state <= ata_rd_pkg::S_DRQ;
          end
        end
        ata_rd_pkg::S_DRQ: begin
          if (sector_done) begin
            tf_count <= tf_count - ata_rd_pkg::ONE_SECTOR;
            if (tf_count == ata_rd_pkg::ONE_SECTOR) begin
              state <= ata_rd_pkg::S_IDLE;
            end else begin
              addr <= step_addr;
              state <= ata_rd_pkg::S_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // media request and word counting
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      med_req <= 1'b0;
      med_cmd <= '0;
    end else begin
      med_req <= (state == ata_rd_pkg::S_ISSUE);
      if (state == ata_rd_pkg::S_ISSUE) begin
        med_cmd.addr <= addr;
        med_cmd.lba <= lba;
        med_cmd.retry_off <= cur_cmd[0] && !is_mult;
        med_cmd.stream <= !is_verify;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word_cnt <= 8'h00;
      blk_cnt <= 8'h00;
    end else begin
      if (cmd_wr) begin
        word_cnt <= 8'h00;
        blk_cnt <= 8'h00;
      end else if (pop) begin
        word_cnt <= word_cnt + 8'h01;
        if (sector_done) begin
          // a block size of zero or one degrades to one interrupt per sector
          blk_cnt <= (blk_cnt + 8'h01 >= multiple_count) ? 8'h00 : blk_cnt + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // host interrupt and read port
  // ---------------------------------------------------------------
  assign irq_set = (ack_ok && !is_verify && (!is_mult || blk_cnt == 8'h00))
                   || ((state == ata_rd_pkg::S_WAIT) && med_ack && (med_unc || is_verify
                       && tf_count == ata_rd_pkg::ONE_SECTOR))
                   || (cmd_wr && !(tf_wdata inside {ata_rd_pkg::CMD_READ,
                       ata_rd_pkg::CMD_READ_NR, ata_rd_pkg::CMD_READ_MULT,
                       ata_rd_pkg::CMD_VERIFY, ata_rd_pkg::CMD_VERIFY_NR}));
  assign irq_clr = tf_rd && (tf_addr == ata_rd_pkg::TF_STATUS);

  // a new event beats the status read that would clear it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) intrq <= 1'b0;
    else if (irq_set) intrq <= 1'b1;
    else if (irq_clr) intrq <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tf_rdata <= 16'h0000;
    end else if (tf_rd) begin
      unique case (tf_addr)
        ata_rd_pkg::TF_DATA: tf_rdata <= pop ? fifo_data : 16'h0000;
        ata_rd_pkg::TF_ERROR: tf_rdata <= {8'h00, err_reg};
        ata_rd_pkg::TF_COUNT: tf_rdata <= {8'h00, tf_count[7:0]};
        ata_rd_pkg::TF_SECT: tf_rdata <= {8'h00, addr.sect};
        ata_rd_pkg::TF_CYL_LO: tf_rdata <= {8'h00, addr.cyl[7:0]};
        ata_rd_pkg::TF_CYL_HI: tf_rdata <= {8'h00, addr.cyl[15:8]};
        ata_rd_pkg::TF_DEV_HEAD: begin
          tf_rdata <= {8'h00, ata_rd_pkg::DH_FIXED | {1'b0, lba, 1'b0, dev, addr.head}};
        end
        ata_rd_pkg::TF_STATUS: tf_rdata <= {8'h00, status};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence native_cmd_s;
    cmd_wr && tf_wdata == ata_rd_pkg::CMD_NATIVE_MAX;
  endsequence

  native_lba_a: assert property (native_cmd_s and lba |=> addr == NATIVE_MAX_LBA)
    else $error("native max logical address wrong");
  native_chs_a: assert property (native_cmd_s and !lba
    |=> addr == {NATIVE_MAX_HEAD, NATIVE_MAX_CYL, NATIVE_MAX_SECT})
    else $error("native max geometry wrong");
  native_idle_a: assert property (native_cmd_s |=> state == ata_rd_pkg::S_IDLE && !err)
    else $error("native max did not complete cleanly");
  retry_flag_a: assert property ($rose(med_req) && !is_mult
    |-> med_cmd.retry_off == cur_cmd[0])
    else $error("retry disable not passed to media");
  word_out_a: assert property (pop |=> tf_rdata == $past(fifo_data))
    else $error("data word not delivered");
  zero_count_a: assert property (cmd_wr && tf_count == '0
    && tf_wdata == ata_rd_pkg::CMD_READ |=> tf_count == ata_rd_pkg::ZERO_COUNT_SECTORS)
    else $error("zero count not taken as 256");
  zero_verify_a: assert property (cmd_wr && tf_count == '0
    && tf_wdata == ata_rd_pkg::CMD_VERIFY |=> tf_count == ata_rd_pkg::ZERO_COUNT_SECTORS)
    else $error("zero verify count not taken as 256");
  unc_stop_a: assert property (state == ata_rd_pkg::S_WAIT && med_ack && med_unc
    |=> state == ata_rd_pkg::S_IDLE && err && $stable(addr) && $stable(tf_count) ##1 !med_req)
    else $error("uncorrectable sector did not stop command");
  verify_quiet_a: assert property (is_verify && state != ata_rd_pkg::S_IDLE
    |-> !status[ata_rd_pkg::ST_DRQ] && !(med_req && med_cmd.stream))
    else $error("verify moved data");
  count_step_a: assert property (sector_done |=> tf_count == $past(tf_count) - 9'h001)
    else $error("count not reduced per sector");
  verify_step_a: assert property (ack_ok && is_verify
    |=> tf_count == $past(tf_count) - 9'h001)
    else $error("verify count not reduced");
  last_addr_a: assert property (sector_done && tf_count == ata_rd_pkg::ONE_SECTOR
    |=> $stable(addr) && state == ata_rd_pkg::S_IDLE)
    else $error("last sector address not held");
  // checked at the read port so the returned byte, not just the vector, is covered
  done_status_a: assert property (irq_clr && state == ata_rd_pkg::S_IDLE
    |=> !tf_rdata[ata_rd_pkg::ST_BSY] && !tf_rdata[ata_rd_pkg::ST_DF]
    && !tf_rdata[ata_rd_pkg::ST_COR] && tf_rdata[ata_rd_pkg::ST_ERR] == $past(err))
    else $error("completion status wrong");
  block_irq_a: assert property (ack_ok && is_mult && blk_cnt != 8'h00 && !intrq
    |=> !intrq)
    else $error("interrupt raised inside a block");
  drq_free_a: assert property (status[ata_rd_pkg::ST_DRQ]
    |-> !status[ata_rd_pkg::ST_BSY])
    else $error("data request with busy set");
endmodule : ata_read_command_executor
`default_nettype wire

// ==== verif/media_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// media stand-in: queued requests, 16-bit words
// ----------------------------------------
module media_model (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset, low; requests ignored while low
  input wire logic med_req, // sector request
  input wire ata_rd_pkg::media_req_s med_cmd, // request details
  output logic med_ack, // answer pulse
  output logic med_unc, // uncorrectable flag
  output logic med_word_valid, // word offered
  input wire logic med_word_ready, // word taken
  output logic [15:0] med_word, // data word
  input wire logic [15:0] fail_at, // request number that fails, 0 none
  input wire logic slow, // late answers and word gaps
  output logic [15:0] reqs // requests seen
);
  ata_rd_pkg::media_req_s q[$];
  ata_rd_pkg::media_req_s cmd;
  logic [15:0] served;
  logic bad;

  initial begin
    med_ack = 1'b0;
    med_unc = 1'b0;
    med_word_valid = 1'b0;
    med_word = 16'hA5A5;
    reqs = 16'h0000;
    served = 16'h0000;
  end

  // queued so a request during a stream is never lost
  always @(posedge mclk) begin
    if (rst_b && med_req) begin
      q.push_back(med_cmd);
      reqs = reqs + 16'h0001;
    end
  end

  // idle word toggles so a stale value never passes for data
  always begin
    @(posedge mclk);
    #10;
    if (q.size() == 0) begin
      med_word = ~med_word;
    end else begin
      cmd = q.pop_front();
      served = served + 16'h0001;
      bad = (served == fail_at);
      if (slow) begin
        repeat (5) @(posedge mclk);
        #10;
      end
      med_ack = 1'b1;
      med_unc = bad;
      @(posedge mclk);
      #10;
      med_ack = 1'b0;
      med_unc = 1'b0;
      if (!bad && cmd.stream) begin
        for (int i = 0; i < 256; i++) begin
          med_word_valid = 1'b1;
          med_word = {cmd.addr.sect, i[7:0]};
          do @(posedge mclk); while (!med_word_ready);
          #10;
          if (slow && i % 64 == 32) begin
            med_word_valid = 1'b0;
            med_word = ~med_word;
            repeat (3) @(posedge mclk);
            #10;
          end
        end
        med_word_valid = 1'b0;
      end
    end
  end
endmodule : media_model
`default_nettype wire

// ==== verif/ata_read_command_executor_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module ata_read_command_executor_test;
  localparam logic [27:0] MAX_LBA = 28'h5A3C1E7;
  localparam logic [15:0] MAX_CYL = 16'h2B6D;
  localparam logic [3:0] MAX_HEAD = 4'hC;
  localparam logic [7:0] MAX_SECT = 8'h35;
  logic mclk, rst_b, tf_wr, tf_rd, intrq, med_req, med_ack, med_unc;
  logic med_word_valid, med_word_ready, slow, saw_full, last_retry, last_stream;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata, multiple_count;
  logic [15:0] tf_rdata, med_word, fail_at, reqs, rd, base;
  ata_rd_pkg::media_req_s med_cmd;
  int miscompares, samples_checked, cycles;

  ata_read_command_executor #(.NATIVE_MAX_LBA(MAX_LBA), .NATIVE_MAX_CYL(MAX_CYL),
    .NATIVE_MAX_HEAD(MAX_HEAD), .NATIVE_MAX_SECT(MAX_SECT)) i_ata_read_command_executor (
    .mclk(mclk), .rst_b(rst_b), .tf_addr(tf_addr), .tf_wr(tf_wr), .tf_rd(tf_rd),
    .tf_wdata(tf_wdata), .tf_rdata(tf_rdata), .intrq(intrq), .multiple_count(multiple_count),
    .med_req(med_req), .med_cmd(med_cmd), .med_ack(med_ack), .med_unc(med_unc),
    .med_word_valid(med_word_valid), .med_word_ready(med_word_ready), .med_word(med_word));
  media_model i_media_model (.mclk(mclk), .rst_b(rst_b), .med_req(med_req), .med_cmd(med_cmd),
    .med_ack(med_ack), .med_unc(med_unc), .med_word_valid(med_word_valid),
    .med_word_ready(med_word_ready), .med_word(med_word), .fail_at(fail_at), .slow(slow),
    .reqs(reqs));

  always #50 mclk = ~mclk;

  // ----------------------------------------
  // monitors and hang limit
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (med_req) begin
      last_retry <= med_cmd.retry_off;
      last_stream <= med_cmd.stream;
    end
    if (rst_b && med_word_valid && !med_word_ready) saw_full <= 1'b1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    #10 tf_wr = 1'b1;
    tf_addr = a;
    tf_wdata = d;
    @(posedge mclk);
    #10 tf_wr = 1'b0;
  endtask : wr

  task rdr(input logic [2:0] a);
    @(posedge mclk);
    #10 tf_rd = 1'b1;
    tf_addr = a;
    @(posedge mclk);
    #10 tf_rd = 1'b0;
    rd = tf_rdata;
  endtask : rdr

  task wait_irq;
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #10;
      n++;
    end
    check("interrupt", {15'h0000, intrq}, 16'h0001);
  endtask : wait_irq

  // busy, fault and corrected must read clear
  task status(input logic err, input logic drq);
    rdr(ata_rd_pkg::TF_STATUS);
    check("status", rd & 16'h00AD, {12'h000, drq, 2'b00, err});
  endtask : status

  task poll(input logic drq);
    int n;
    n = 0;
    do begin
      rdr(ata_rd_pkg::TF_STATUS);
      n++;
    end while ((rd[7] || rd[3] !== drq) && n < 100);
    status(1'b0, drq);
  endtask : poll

  task start(input logic [7:0] cmd, input logic [7:0] cnt, input logic [27:0] a);
    wr(ata_rd_pkg::TF_COUNT, cnt);
    wr(ata_rd_pkg::TF_SECT, a[7:0]);
    wr(ata_rd_pkg::TF_CYL_LO, a[15:8]);
    wr(ata_rd_pkg::TF_CYL_HI, a[23:16]);
    wr(ata_rd_pkg::TF_DEV_HEAD, ata_rd_pkg::DH_FIXED | 8'h40 | {4'h0, a[27:24]});
    wr(ata_rd_pkg::TF_STATUS, cmd);
  endtask : start

  task addr_is(input logic [27:0] a, input logic [7:0] cnt);
    rdr(ata_rd_pkg::TF_COUNT);
    check("count", rd, {8'h00, cnt});
    rdr(ata_rd_pkg::TF_SECT);
    check("sector", rd, {8'h00, a[7:0]});
    rdr(ata_rd_pkg::TF_CYL_LO);
    check("cyl low", rd, {8'h00, a[15:8]});
    rdr(ata_rd_pkg::TF_CYL_HI);
    check("cyl high", rd, {8'h00, a[23:16]});
    rdr(ata_rd_pkg::TF_DEV_HEAD);
    check("head", rd & 16'h000F, {12'h000, a[27:24]});
  endtask : addr_is

  // all 256 words of a sector are taken before moving on
  task sector(input logic [7:0] s);
    for (int i = 0; i < 256; i++) begin
      rdr(ata_rd_pkg::TF_DATA);
      check("data word", rd, {s, i[7:0]});
    end
  endtask : sector

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    tf_wr = 1'b0;
    tf_rd = 1'b0;
    tf_addr = 3'h0;
    tf_wdata = 8'h00;
    multiple_count = 8'h00;
    fail_at = 16'h0000;
    slow = 1'b0;
    saw_full = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge mclk);
    #10 rst_b = 1'b1;
    wr(ata_rd_pkg::TF_DEV_HEAD, 8'hE0);
    wr(ata_rd_pkg::TF_STATUS, ata_rd_pkg::CMD_NATIVE_MAX);
    wait_irq();
    status(1'b0, 1'b0);
    addr_is(MAX_LBA, 8'h00);
    wr(ata_rd_pkg::TF_DEV_HEAD, ata_rd_pkg::DH_FIXED);
    wr(ata_rd_pkg::TF_STATUS, ata_rd_pkg::CMD_NATIVE_MAX);
    wait_irq();
    status(1'b0, 1'b0);
    addr_is({MAX_HEAD, MAX_CYL, MAX_SECT}, 8'h00);
    // unknown code is aborted with an interrupt
    wr(ata_rd_pkg::TF_STATUS, 8'hE5);
    wait_irq();
    status(1'b1, 1'b0);
    rdr(ata_rd_pkg::TF_ERROR);
    check("abort", rd & 16'h0044, 16'h0004);
    // slow media, address carries across a byte
    slow = 1'b1;
    start(ata_rd_pkg::CMD_READ, 8'h03, 28'h00012FE);
    for (int s = 0; s < 3; s++) begin
      wait_irq();
      status(1'b0, 1'b1);
      sector(8'hFE + 8'(s));
    end
    poll(1'b0);
    check("retry off", {15'h0000, last_retry}, 16'h0000);
    addr_is(28'h0001300, 8'h00);
    check("fifo refused", {15'h0000, saw_full}, 16'h0001);
    // two-sector block raises one interrupt
    slow = 1'b0;
    multiple_count = 8'h02;
    start(ata_rd_pkg::CMD_READ_MULT, 8'h02, 28'h0000040);
    wait_irq();
    status(1'b0, 1'b1);
    sector(8'h40);
    // look before any status read could clear a stray interrupt
    repeat (20) @(posedge mclk);
    #10 check("block interrupt", {15'h0000, intrq}, 16'h0000);
    poll(1'b1);
    sector(8'h41);
    check("end interrupt", {15'h0000, intrq}, 16'h0000);
    poll(1'b0);
    addr_is(28'h0000041, 8'h00);
    // cylinder/head/sector read wraps sector and head into the next cylinder
    wr(ata_rd_pkg::TF_COUNT, 8'h02);
    wr(ata_rd_pkg::TF_SECT, MAX_SECT);
    wr(ata_rd_pkg::TF_CYL_LO, 8'h07);
    wr(ata_rd_pkg::TF_CYL_HI, 8'h00);
    wr(ata_rd_pkg::TF_DEV_HEAD, ata_rd_pkg::DH_FIXED | {4'h0, MAX_HEAD});
    wr(ata_rd_pkg::TF_STATUS, ata_rd_pkg::CMD_READ_NR);
    for (int s = 0; s < 2; s++) begin
      wait_irq();
      status(1'b0, 1'b1);
      sector((s == 0) ? MAX_SECT : 8'h01);
    end
    poll(1'b0);
    check("retry off", {15'h0000, last_retry}, 16'h0001);
    addr_is(28'h0000801, 8'h00);
    // verify stops at the failing second sector
    fail_at = reqs + 16'h0002;
    start(ata_rd_pkg::CMD_VERIFY_NR, 8'h03, 28'h0000500);
    wait_irq();
    status(1'b1, 1'b0);
    rdr(ata_rd_pkg::TF_ERROR);
    check("error", rd & 16'h0044, 16'h0040);
    addr_is(28'h0000501, 8'h02);
    check("retry off", {15'h0000, last_retry}, 16'h0001);
    check("stream", {15'h0000, last_stream}, 16'h0000);
    // count zero verifies 256 sectors
    fail_at = 16'h0000;
    base = reqs;
    start(ata_rd_pkg::CMD_VERIFY, 8'h00, 28'h0000100);
    wait_irq();
    status(1'b0, 1'b0);
    check("verify requests", reqs - base, 16'h0100);
    addr_is(28'h00001FF, 8'h00);
    // count zero read fails on its first sector
    base = reqs;
    fail_at = reqs + 16'h0001;
    start(ata_rd_pkg::CMD_READ, 8'h00, 28'h0000200);
    wait_irq();
    status(1'b1, 1'b0);
    addr_is(28'h0000200, 8'h00);
    check("read requests", reqs - base, 16'h0001);
    complete_run();
  end
endmodule : ata_read_command_executor_test
`default_nettype wire
